// ==== svgs_pkg.sv ====
/*
 package for the servo gain switching block: register map, field positions,
 reset values, switching condition codes and timing constants.
 assumes a 100 MHz core clock and 16-bit gain settings.
*/
// Notes on behaviour
// (R1) auto cutoff is speed gain over one-plus-inertia times ten
// (R2) middle lowpass digit 1 selects manual cutoff
// (R3) switch six loop gains on selected condition
// (R4) switching only when autotune mode is 3
// (R5) model loop gain always in effect
// (R6) base settings active before switching
// (R7) alternate settings active after switching
// (R8) first digit 1 means external input switches
// (R9) switch input routable to any general input
// (R10) threshold compared in unit of chosen condition
// (R11) first-order lag, time constant in ms
// (R12) vibration frequencies switch only via external input
// (R13) hold alternate vibration and resonance frequencies
// (R14) selection 001 switches on external input state
// (R15) selection 003 compares droop pulses to threshold
// (R16) at or above threshold selects alternate set
package svgs_pkg;
    localparam int GW = 16;
    localparam int NGAIN = 6;
    localparam int FRAC = 16;

    localparam logic [7:0] OFS_AUTOTUNE = 8'h00;
    localparam logic [7:0] OFS_SWSEL = 8'h04;
    localparam logic [7:0] OFS_THRESH = 8'h08;
    localparam logic [7:0] OFS_TCONST = 8'h0C;
    localparam logic [7:0] OFS_LPSEL = 8'h10;
    localparam logic [7:0] OFS_LPMAN = 8'h14;
    localparam logic [7:0] OFS_INSEL = 8'h18;
    localparam logic [7:0] OFS_MODEL = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h80;
    localparam logic [7:0] OFS_LPOUT = 8'h84;
    // gain banks: base 0x20, alternate 0x40, active 0x60, one word per gain
    localparam logic [2:0] BANK_BASE = 3'h1;
    localparam logic [2:0] BANK_ALT = 3'h2;
    localparam logic [2:0] BANK_ACT = 3'h3;

    localparam int G_INERTIA = 0;
    localparam int G_POS = 1;
    localparam int G_SPD = 2;
    localparam int G_INTEG = 3;
    localparam int G_VIB = 4;
    localparam int G_RES = 5;

    // inertia ratio held in tenths
    localparam logic [NGAIN-1:0][GW-1:0] RST_BASE = {16'h0032, 16'h0032, 16'h0014, 16'h0BB8, 16'h0078, 16'h0028};
    localparam logic [NGAIN-1:0][GW-1:0] RST_ALT = {16'h003C, 16'h003C, 16'h0032, 16'h0FA0, 16'h0054, 16'h0064};
    localparam logic [3:0] RST_AUTOTUNE = 4'h3;
    localparam logic [11:0] RST_SWSEL = 12'h000;
    localparam logic [15:0] RST_THRESH = 16'h0032;
    localparam logic [15:0] RST_TCONST = 16'h0064;
    localparam logic [11:0] RST_LPSEL = 12'h000;
    localparam logic [15:0] RST_LPMAN = 16'h0000;
    localparam logic [2:0] RST_INSEL = 3'h0;
    localparam logic [15:0] RST_MODEL = 16'h0064;

    localparam int SW_COND_LSB = 0;
    localparam int SW_DIG2_LSB = 4;
    localparam int LP_MID_LSB = 4;
    localparam logic [3:0] LP_MANUAL = 4'h1;
    localparam logic [3:0] AT_MANUAL = 4'h3;
    localparam logic [3:0] COND_EXT = 4'h1;
    localparam logic [3:0] COND_CMD = 4'h2;
    localparam logic [3:0] COND_DROOP = 4'h3;
    localparam logic [3:0] COND_SPEED = 4'h4;

    localparam int ST_ALT = 0;
    localparam int ST_EN = 1;
    localparam int ST_MANLP = 2;

    localparam logic [31:0] LP_MUL = 32'h0000_0064;
    localparam logic [16:0] INERTIA_ONE = 17'h0000A;
    localparam logic [31:0] RCP_NUM = 32'h0001_0000;
    localparam logic [16:0] RCP_UNITY = 17'h10000;

    localparam int CLK_NS = 10;
    localparam int TIME_MS_NS = 1000000;
    localparam int MS_CYCLES = (TIME_MS_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ==== svgs_div.sv ====
/*
 sequential restoring divider, one quotient bit per enabled clock.
 assumes start is raised only while busy is low; divide by zero gives all ones.
*/
`timescale 1ns/1ps
module svgs_div #(
    parameter int NW = 32,
    parameter int DW = 17
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic start,
    input wire logic [NW-1:0] num,
    input wire logic [DW-1:0] den,
    output logic busy,
    output logic done,
    output logic [NW-1:0] quo
);
    if (NW < 2 || DW < 1) begin : g_chk
        $error("svgs_div: width too small");
    end
    logic [NW-1:0] q_ff;
    logic [DW:0] r_ff;
    logic [DW-1:0] d_ff;
    logic [7:0] cnt_ff;
    logic busy_ff;
    logic done_ff;
    logic [DW:0] sh;
    assign sh = {r_ff[DW-1:0], q_ff[NW-1]};
    always_ff @(posedge core_clk) begin
        if (srst) begin
            q_ff <= '0;
            r_ff <= '0;
            d_ff <= '0;
            cnt_ff <= 8'h00;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (ce) begin
            done_ff <= 1'b0;
            if (start && !busy_ff) begin
                q_ff <= num;
                r_ff <= '0;
                d_ff <= den;
                cnt_ff <= 8'(NW);
                busy_ff <= 1'b1;
            end else if (busy_ff) begin
                if (sh >= {1'b0, d_ff}) begin
                    r_ff <= sh - {1'b0, d_ff};
                    q_ff <= {q_ff[NW-2:0], 1'b1};
                end else begin
                    r_ff <= sh;
                    q_ff <= {q_ff[NW-2:0], 1'b0};
                end
                cnt_ff <= cnt_ff - 8'h01;
                if (cnt_ff == 8'h01) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end
            end
        end
    end
    assign busy = busy_ff;
    assign done = done_ff;
    assign quo = q_ff;
endmodule

// ==== svgs_lag.sv ====
/*
 first-order lag on one gain: y moves toward x by (x - y) * rcp / 2^F per tick.
 assumes rcp is at most 2^F so a step never overshoots; bypass makes y follow x.
*/
`timescale 1ns/1ps
module svgs_lag #(
    parameter int W = 16,
    parameter int F = 16,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic tick,
    input wire logic bypass,
    input wire logic [W-1:0] x,
    input wire logic [F:0] rcp,
    output logic [W-1:0] y
);
    if (W < 1 || F < 1) begin : g_chk
        $error("svgs_lag: width too small");
    end
    logic signed [W+F+1:0] acc_ff;
    logic [W-1:0] y_ff;
    logic signed [W+F+1:0] diff;
    logic signed [W+2*F+3:0] prod;
    assign diff = $signed({2'b00, x, {F{1'b0}}}) - acc_ff;
    assign prod = diff * $signed({1'b0, rcp});
    always_ff @(posedge core_clk) begin
        if (srst) begin
            acc_ff <= $signed({2'b00, INIT, {F{1'b0}}});
            y_ff <= INIT;
        end else if (ce) begin
            if (bypass) begin
                acc_ff <= $signed({2'b00, x, {F{1'b0}}});
            end else if (tick) begin
                acc_ff <= acc_ff + prod[W+2*F+1:F];
            end
            y_ff <= acc_ff[W+F-1:F];
        end
    end
    assign y = y_ff;
endmodule

// ==== svgs_gain_switch.sv ====
/*
 gain switching core: register file on classic wishbone, switch decision,
 per-gain lag filters and torque-command lowpass cutoff.
 assumes cmdFreq, droopPulses and motorSpeed come from logic on core_clk;
 gpIn are pins and are synchronised here.
*/
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module svgs_gain_switch
    import svgs_pkg::*;
#(
    parameter int NIN = 6,
    parameter int MS_CYC = svgs_pkg::MS_CYCLES
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NIN-1:0] gpIn,
    input wire logic [svgs_pkg::GW-1:0] cmdFreq,
    input wire logic signed [svgs_pkg::GW-1:0] droopPulses,
    input wire logic signed [svgs_pkg::GW-1:0] motorSpeed,
    output logic [svgs_pkg::GW-1:0] loadInertiaRatio,
    output logic [svgs_pkg::GW-1:0] positionLoopGain,
    output logic [svgs_pkg::GW-1:0] speedLoopGain,
    output logic [svgs_pkg::GW-1:0] speedIntegralComp,
    output logic [svgs_pkg::GW-1:0] vibrationFreq,
    output logic [svgs_pkg::GW-1:0] resonanceFreq,
    output logic [svgs_pkg::GW-1:0] modelLoopGain,
    output logic [svgs_pkg::GW-1:0] lowpassFreq,
    output logic altSetActive
);
    import svgs_pkg::*;

    if (NIN < 1 || NIN > 8 || MS_CYC < 2) begin : g_chk
        $error("svgs_gain_switch: bad parameter");
    end

    function automatic logic [15:0] wmask(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
        wmask = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic [15:0] mag(input logic signed [15:0] v);
        mag = v[15] ? 16'(-v) : 16'(v);
    endfunction

    function automatic logic [15:0] sat16(input logic [31:0] v);
        sat16 = (v > 32'h0000_FFFF) ? 16'hFFFF : v[15:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register file

    logic [3:0] autotune_ff;
    logic [11:0] swSel_ff;
    logic [15:0] thr_ff;
    logic [15:0] tconst_ff;
    logic [11:0] lpSel_ff;
    logic [15:0] lpMan_ff;
    logic [2:0] inSel_ff;
    logic [15:0] model_ff;
    logic [15:0] base_ff [NGAIN];
    logic [15:0] alt_ff [NGAIN];
    logic ack_ff;
    logic [31:0] datO_ff;
    logic [31:0] rdData;
    logic [2:0] idx;
    logic req;
    logic wrEn;
    logic altSel_ff;
    logic swEnable;
    logic lpManual;
    logic [15:0] lpFreq_ff;
    logic [15:0] act [NGAIN];

    assign req = wb_cyc_i & wb_stb_i;
    // write lands on the edge where the master sees ack
    assign wrEn = req & wb_we_i & ack_ff;
    assign idx = wb_adr_i[4:2];

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ack_ff <= 1'b0;
        end else if (ce) begin
            ack_ff <= req & ~ack_ff;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            datO_ff <= 32'h0000_0000;
        end else if (ce && req && !ack_ff) begin
            datO_ff <= rdData;
        end
    end

    always_comb begin
        rdData = 32'h0000_0000;
        case (wb_adr_i)
            OFS_AUTOTUNE: rdData = {28'h0000000, autotune_ff};
            OFS_SWSEL: rdData = {20'h00000, swSel_ff};
            OFS_THRESH: rdData = {16'h0000, thr_ff};
            OFS_TCONST: rdData = {16'h0000, tconst_ff};
            OFS_LPSEL: rdData = {20'h00000, lpSel_ff};
            OFS_LPMAN: rdData = {16'h0000, lpMan_ff};
            OFS_INSEL: rdData = {29'h00000000, inSel_ff};
            OFS_MODEL: rdData = {16'h0000, model_ff};
            OFS_STATUS: rdData = {29'h00000000, lpManual, swEnable, altSel_ff};
            OFS_LPOUT: rdData = {16'h0000, lpFreq_ff};
            default: begin
                if (wb_adr_i[1:0] == 2'b00 && 32'(idx) < NGAIN) begin
                    if (wb_adr_i[7:5] == BANK_BASE) begin
                        rdData = {16'h0000, base_ff[idx]};
                    end else if (wb_adr_i[7:5] == BANK_ALT) begin
                        rdData = {16'h0000, alt_ff[idx]};
                    end else if (wb_adr_i[7:5] == BANK_ACT) begin
                        rdData = {16'h0000, act[idx]};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            autotune_ff <= RST_AUTOTUNE;
            swSel_ff <= RST_SWSEL;
            thr_ff <= RST_THRESH;
            tconst_ff <= RST_TCONST;
            lpSel_ff <= RST_LPSEL;
            lpMan_ff <= RST_LPMAN;
            inSel_ff <= RST_INSEL;
            model_ff <= RST_MODEL;
        end else if (ce && wrEn) begin
            case (wb_adr_i)
                OFS_AUTOTUNE: autotune_ff <= 4'(wmask({12'h000, autotune_ff}, wb_dat_i, wb_sel_i));
                OFS_SWSEL: swSel_ff <= 12'(wmask({4'h0, swSel_ff}, wb_dat_i, wb_sel_i));
                OFS_THRESH: thr_ff <= wmask(thr_ff, wb_dat_i, wb_sel_i);
                OFS_TCONST: tconst_ff <= wmask(tconst_ff, wb_dat_i, wb_sel_i);
                OFS_LPSEL: lpSel_ff <= 12'(wmask({4'h0, lpSel_ff}, wb_dat_i, wb_sel_i));
                OFS_LPMAN: lpMan_ff <= wmask(lpMan_ff, wb_dat_i, wb_sel_i);
                OFS_INSEL: inSel_ff <= 3'(wmask({13'h0000, inSel_ff}, wb_dat_i, wb_sel_i));
                OFS_MODEL: model_ff <= wmask(model_ff, wb_dat_i, wb_sel_i);
                default: ;
            endcase
        end
    end

    // base and alternate banks, alternate vibration pair included
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int i = 0; i < NGAIN; i++) begin
                base_ff[i] <= RST_BASE[i];
                alt_ff[i] <= RST_ALT[i]; // R13
            end
        end else if (ce && wrEn && wb_adr_i[1:0] == 2'b00 && 32'(idx) < NGAIN) begin
            if (wb_adr_i[7:5] == BANK_BASE) begin
                base_ff[idx] <= wmask(base_ff[idx], wb_dat_i, wb_sel_i);
            end else if (wb_adr_i[7:5] == BANK_ALT) begin
                alt_ff[idx] <= wmask(alt_ff[idx], wb_dat_i, wb_sel_i); // R13
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = datO_ff;

    ////////////////////////////////////////////////////////////////////////
    // switch decision

    logic [NIN-1:0] gpMeta_ff;
    logic [NIN-1:0] gpSync_ff;
    logic extIn;
    logic swLevel;
    logic [3:0] cond;
    logic [15:0] droopMag;
    logic [15:0] speedMag;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            gpMeta_ff <= '0;
            gpSync_ff <= '0;
        end else if (ce) begin
            gpMeta_ff <= gpIn;
            gpSync_ff <= gpMeta_ff;
        end
    end

    // out-of-range terminal index reads as off
    assign extIn = (32'(inSel_ff) < NIN) ? gpSync_ff[inSel_ff] : 1'b0; // R9
    assign cond = swSel_ff[SW_COND_LSB +: 4];
    assign swEnable = (autotune_ff == AT_MANUAL); // R4
    assign droopMag = mag(droopPulses);
    assign speedMag = mag(motorSpeed);

    always_comb begin
        swLevel = 1'b0;
        case (cond) // R8
            COND_EXT: swLevel = extIn; // R14
            COND_CMD: swLevel = (cmdFreq >= thr_ff); // R10 R16
            COND_DROOP: swLevel = (droopMag >= thr_ff); // R15 R16
            COND_SPEED: swLevel = (speedMag >= thr_ff); // R10 R16
            default: swLevel = 1'b0;
        endcase
        // second digit has no defined condition, so nonzero means no switching
        if (swSel_ff[SW_DIG2_LSB +: 4] != 4'h0) begin
            swLevel = 1'b0; // R8
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            altSel_ff <= 1'b0;
        end else if (ce) begin
            altSel_ff <= swEnable & swLevel; // R3 R4
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // targets and lag filters

    logic [15:0] target [NGAIN];
    logic [31:0] msCnt_ff;
    logic msTick_ff;
    logic [16:0] rcp_ff;
    logic tcZero;

    always_comb begin
        for (int i = 0; i < NGAIN; i++) begin
            target[i] = altSel_ff ? alt_ff[i] : base_ff[i]; // R6 R7
        end
        if (cond != COND_EXT) begin
            target[G_VIB] = base_ff[G_VIB]; // R12
            target[G_RES] = base_ff[G_RES]; // R12
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            msCnt_ff <= 32'h0000_0000;
            msTick_ff <= 1'b0;
        end else if (ce) begin
            msTick_ff <= (msCnt_ff == 32'(MS_CYC - 1));
            msCnt_ff <= (msCnt_ff == 32'(MS_CYC - 1)) ? 32'h0000_0000 : msCnt_ff + 32'h0000_0001;
        end
    end

    // zero time constant switches in one step
    assign tcZero = (tconst_ff == 16'h0000);

    for (genvar g = 0; g < NGAIN; g++) begin : g_lag
        svgs_lag #(.W(GW), .F(FRAC), .INIT(RST_BASE[g])) u_lag ( // R11
            .core_clk(core_clk),
            .srst(srst),
            .ce(ce),
            .tick(msTick_ff),
            .bypass(tcZero),
            .x(target[g]),
            .rcp(rcp_ff),
            .y(act[g])
        );
    end

    assign loadInertiaRatio = act[G_INERTIA];
    assign positionLoopGain = act[G_POS];
    assign speedLoopGain = act[G_SPD];
    assign speedIntegralComp = act[G_INTEG];
    assign vibrationFreq = act[G_VIB];
    assign resonanceFreq = act[G_RES];
    assign modelLoopGain = model_ff; // R5
    assign altSetActive = altSel_ff;

    ////////////////////////////////////////////////////////////////////////
    // shared divider: lowpass cutoff and lag reciprocal in turn

    typedef enum logic [1:0] {DV_LP_GO, DV_LP_WAIT, DV_TC_GO, DV_TC_WAIT} svgs_dv_e;
    svgs_dv_e dvState_ff;
    logic dvStart;
    logic dvDone;
    logic [31:0] dvNum;
    logic [16:0] dvDen;
    logic [31:0] dvQuo;
    logic [15:0] lpAuto_ff;

    assign dvStart = (dvState_ff == DV_LP_GO) || (dvState_ff == DV_TC_GO);
    // cutoff uses active gains, so it tracks the lag while switching
    assign dvNum = (dvState_ff == DV_LP_GO) ? 32'(act[G_SPD]) * LP_MUL : RCP_NUM; // R1
    assign dvDen = (dvState_ff == DV_LP_GO) ? {1'b0, act[G_INERTIA]} + INERTIA_ONE : {1'b0, tconst_ff}; // R1 R11

    svgs_div #(.NW(32), .DW(17)) u_div (
        .core_clk(core_clk),
        .srst(srst),
        .ce(ce),
        .start(dvStart),
        .num(dvNum),
        .den(dvDen),
        .busy(),
        .done(dvDone),
        .quo(dvQuo)
    );

    always_ff @(posedge core_clk) begin
        if (srst) begin
            dvState_ff <= DV_LP_GO;
        end else if (ce) begin
            case (dvState_ff)
                DV_LP_GO: dvState_ff <= DV_LP_WAIT;
                DV_LP_WAIT: if (dvDone) dvState_ff <= DV_TC_GO;
                DV_TC_GO: dvState_ff <= DV_TC_WAIT;
                DV_TC_WAIT: if (dvDone) dvState_ff <= DV_LP_GO;
                default: dvState_ff <= DV_LP_GO;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            lpAuto_ff <= 16'h0000;
            rcp_ff <= RCP_UNITY;
        end else if (ce && dvDone) begin
            if (dvState_ff == DV_LP_WAIT) begin
                lpAuto_ff <= sat16(dvQuo); // R1
            end else if (dvState_ff == DV_TC_WAIT) begin
                rcp_ff <= tcZero ? RCP_UNITY : dvQuo[16:0]; // R11
            end
        end
    end

    assign lpManual = (lpSel_ff[LP_MID_LSB +: 4] == LP_MANUAL);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            lpFreq_ff <= 16'h0000;
        end else if (ce) begin
            lpFreq_ff <= lpManual ? lpMan_ff : lpAuto_ff; // R1 R2
        end
    end

    assign lowpassFreq = lpFreq_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    a_lp_quotient: assert property (ce && dvDone && dvState_ff == DV_LP_WAIT |=> lpAuto_ff == sat16($past(dvQuo))) // R1
        else $error("auto cutoff not taken from quotient");
    a_lp_manual: assert property (ce && lpManual |=> lowpassFreq == $past(lpMan_ff)) // R2
        else $error("manual cutoff not applied");
    a_lp_auto: assert property (ce && !lpManual |=> lowpassFreq == $past(lpAuto_ff)) // R1
        else $error("auto cutoff not applied");
    a_switch_off: assert property (ce && !swEnable |=> !altSel_ff) // R4
        else $error("switched outside manual tuning mode");
    a_model_kept: assert property (ce && altSel_ff != $past(altSel_ff) |-> $stable(modelLoopGain)) // R5
        else $error("model gain moved on switch");
    a_ext_follow: assert property (ce && swEnable && swSel_ff == 12'h001 |=> altSel_ff == $past(extIn)) // R14
        else $error("external switch not followed");
    a_droop_level: assert property (ce && swEnable && swSel_ff == 12'h003 |=> altSel_ff == ($past(droopMag) >= $past(thr_ff))) // R15
        else $error("droop threshold compare wrong");
    a_vib_thresh: assert property ((ce && tcZero && cond != COND_EXT) [*3] |-> // R12
        vibrationFreq == $past(base_ff[G_VIB], 2) && resonanceFreq == $past(base_ff[G_RES], 2))
        else $error("vibration pair switched by threshold");
    a_base_target: assert property ((ce && tcZero && !altSel_ff) [*3] |-> // R6
        speedLoopGain == $past(base_ff[G_SPD], 2) && loadInertiaRatio == $past(base_ff[G_INERTIA], 2))
        else $error("base gain not targeted");
    a_alt_target: assert property ((ce && tcZero && altSel_ff) [*3] |-> // R7
        positionLoopGain == $past(alt_ff[G_POS], 2) && speedIntegralComp == $past(alt_ff[G_INTEG], 2))
        else $error("alternate gain not targeted");
    a_lag_bypass: assert property ((ce && tcZero) [*3] |-> speedLoopGain == $past(target[G_SPD], 2)) // R11
        else $error("zero time constant did not pass gain");

    c_alt_rise: cover property (ce && !altSel_ff ##1 altSel_ff);
    c_droop_switch: cover property (altSel_ff && cond == COND_DROOP);
    c_ext_vib: cover property (altSel_ff && cond == COND_EXT && target[G_VIB] != base_ff[G_VIB]);
    c_manual_lp: cover property (lpManual && lowpassFreq == lpMan_ff);
endmodule

// ==== svgs_host_model.sv ====
/*
 host side model: drives the general input pins of the gain switch block.
 assumes pinIdx and swLevel change just after a rising core_clk edge.
*/
`timescale 1ns/1ps
module svgs_host_model #(
    parameter int NIN = 6
) (
    input wire logic core_clk,
    input wire logic [2:0] pinIdx,
    input wire logic swLevel,
    output logic [NIN-1:0] gpIn
);
    logic [NIN-1:0] noise_ff = '0;
    ////////////////////////////////////////////////////////////////////////
    // unused pins toggle every cycle so a wrong pin choice cannot hide
    always @(posedge core_clk) begin
        noise_ff <= ~noise_ff;
    end
    always_comb begin
        gpIn = noise_ff;
        gpIn[pinIdx] = swLevel;
    end
endmodule

// ==== tb_servo_gain_switching.sv ====
/*
 self-checking bench for the gain switch block: wishbone tasks, random sweeps.
 assumes MS_CYC of 20 so one lag tick is 20 cycles.
*/
`timescale 1ns/1ps
module tb_servo_gain_switching;
    import svgs_pkg::*;
    logic core_clk = 0, srst = 1, ce = 1, cyc = 0, stb = 0, we = 0, ack, altAct, swLevel = 0;
    logic [7:0] adr = '0;
    logic [3:0] sel = '0;
    logic [31:0] wdat = '0, wbDat, rd;
    logic [2:0] pinIdx = '0;
    logic [5:0] gpIn;
    logic [15:0] cmdFreq = '0, modelGain, lpFreq;
    logic signed [15:0] droop = '0, speed = '0;
    logic [15:0] gain [NGAIN];
    int num_errors = 0, n_compared = 0;
    always #5 core_clk = ~core_clk;
    svgs_gain_switch #(.NIN(6), .MS_CYC(20)) dut (.core_clk(core_clk), .srst(srst), .ce(ce), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wbDat),
        .wb_ack_o(ack), .gpIn(gpIn), .cmdFreq(cmdFreq), .droopPulses(droop), .motorSpeed(speed),
        .loadInertiaRatio(gain[0]), .positionLoopGain(gain[1]), .speedLoopGain(gain[2]),
        .speedIntegralComp(gain[3]), .vibrationFreq(gain[4]), .resonanceFreq(gain[5]),
        .modelLoopGain(modelGain), .lowpassFreq(lpFreq), .altSetActive(altAct));
    svgs_host_model #(.NIN(6)) host (.core_clk(core_clk), .pinIdx(pinIdx), .swLevel(swLevel), .gpIn(gpIn));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge core_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) num_errors++;
        rd = wbDat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge core_clk);
    endtask
    // saturating cutoff; inertia held in tenths
    function automatic logic [15:0] lpExp(input int spd, input int inr);
        int q;
        q = spd * 100 / (10 + inr);
        return (q > 65535) ? 16'hFFFF : q[15:0];
    endfunction
    function automatic logic altExp(input int v, input int thr);
        return ((v < 0) ? -v : v) >= thr;
    endfunction
    task automatic chkSet(input logic alt, input logic vibAlt);
        for (int i = 0; i < NGAIN; i++) chk(gain[i], ((i < 4) ? alt : vibAlt) ? RST_ALT[i] : RST_BASE[i]);
    endtask
    task print_verdict;
        $display("errors=%0d compared=%0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        print_verdict;
    end
    initial begin
        int v, o, m, idx;
        v = $urandom(74);
        idx = $urandom_range(5);
        wt(20);
        srst <= 1'b0;
        wt(80);
        chkSet(0, 0);
        chk(modelGain, 16'h0064);
        chk(lpFreq, lpExp(RST_BASE[G_SPD], RST_BASE[G_INERTIA]));
        wb(0, OFS_AUTOTUNE, 0);
        chk(rd, 32'h3);
        wb(1, OFS_TCONST, 0);
        wb(1, OFS_INSEL, idx);
        wb(1, OFS_SWSEL, 32'h1);
        pinIdx <= idx[2:0];
        swLevel <= 1'b1;
        wt(100);
        chk(altAct, 1'b1);
        chkSet(1, 1);
        chk(modelGain, 16'h0064);
        chk(lpFreq, lpExp(RST_ALT[G_SPD], RST_ALT[G_INERTIA]));
        wb(0, 8'h68, 0);
        chk(rd, RST_ALT[G_SPD]);
        wb(1, OFS_AUTOTUNE, 32'h1);
        wt(6);
        chk(altAct, 1'b0);
        chkSet(0, 0);
        wb(1, OFS_AUTOTUNE, 32'h3);
        swLevel <= 1'b0;
        wt(8);
        chk(altAct, 1'b0);
        for (m = 2; m <= 4; m++) begin
            wb(1, OFS_SWSEL, m);
            for (int k = 0; k < 12; k++) begin
                v = (k == 0) ? 49 : (k == 1) ? 50 : (k == 2) ? -50 : int'($urandom_range(200)) - 100;
                if (m == 2 && v < 0) v = -v;
                o = altExp(v, 50) ? 0 : 200;
                cmdFreq <= 16'((m == 2) ? v : o);
                droop <= 16'((m == 3) ? v : o);
                speed <= 16'((m == 4) ? v : o);
                wt(6);
                chk(altAct, altExp(v, 50));
                chkSet(altExp(v, 50), 0);
            end
        end
        v = $urandom_range(65535);
        wb(1, OFS_LPMAN, v);
        wb(1, OFS_LPSEL, 32'h010);
        wt(3);
        chk(lpFreq, v);
        // lag check: T of 4 ms moves a quarter of the gap each tick
        wb(1, OFS_SWSEL, 32'h1);
        wb(1, OFS_TCONST, 32'h4);
        wt(100);
        swLevel <= 1'b1;
        wt(30);
        chk(gain[G_SPD] > RST_BASE[G_SPD] && gain[G_SPD] < RST_ALT[G_SPD], 1'b1);
        wb(1, OFS_SWSEL, 32'h11);
        wt(6);
        chk(altAct, 1'b0);
        wb(0, 8'hF0, 0);
        chk(rd, 32'h0);
        print_verdict;
    end
endmodule
